// ==== smie_pkg.sv ====
// package for the shift, move and indirect-load execution block
// assumes a single core clock and a synchronous-read data memory
package smie_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PTR_W = 16;
    localparam int FADDR_W = 7;
    localparam int BANK_W = 5;
    localparam int OFS_W = 6;

    // ------------------------------------------------------------
    // alias addresses and reset values
    // ------------------------------------------------------------
    localparam logic [FADDR_W-1:0] ALIAS0_ADDR = 7'h00;
    localparam logic [FADDR_W-1:0] ALIAS1_ADDR = 7'h01;
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [DATA_W-1:0] W_RST = 8'h00;
    localparam logic CARRY_RST = 1'b0;
    localparam logic ZERO_RST = 1'b0;

    // ------------------------------------------------------------
    // destination bit and pointer update codes
    // ------------------------------------------------------------
    localparam logic DEST_W = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam logic [1:0] UPD_PRE_INC = 2'h0;
    localparam logic [1:0] UPD_PRE_DEC = 2'h1;
    localparam logic [1:0] UPD_POST_INC = 2'h2;
    localparam logic [1:0] UPD_POST_DEC = 2'h3;

    // ------------------------------------------------------------
    // operations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SMIE_OP_NONE = 2'h0,
        logical_right_shift_op = 2'h1,
        file_copy_op = 2'h2,
        indirect_load_op = 2'h3
    } smie_op_t;

    typedef struct packed {
        smie_op_t op;
        logic [FADDR_W-1:0] faddr;
        logic dest;
        logic ptr_sel;
        logic [1:0] pointer_update_code;
        logic rel;
        logic [OFS_W-1:0] offset;
    } smie_instr_t;

    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [PTR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } smie_mem_req_t;

    typedef struct packed {
        logic wr;
        logic sel;
        logic [PTR_W-1:0] data;
    } smie_ptr_load_t;

endpackage

// ==== smie_ptr_unit.sv ====
// pointer arithmetic for the indirect load
// assumes the caller registers the results; purely combinational
`timescale 1ns/1ps

module smie_ptr_unit
    import smie_pkg::*;
#(
    parameter int P_W = PTR_W,
    parameter int O_W = OFS_W
) (
    // pointer and mode
    input wire logic [P_W-1:0] ptr_i,
    input wire logic [1:0] upd_i,
    input wire logic rel_i,
    input wire logic [O_W-1:0] offset_i,
    // results
    output logic [P_W-1:0] eff_addr_o,
    output logic [P_W-1:0] new_ptr_o
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (P_W < FADDR_W || O_W >= P_W) begin : g_bad
        $error("smie_ptr_unit: pointer width too small");
    end

    logic [P_W-1:0] ptr_inc;
    logic [P_W-1:0] ptr_dec;
    logic [P_W-1:0] ofs_ext;

    // ------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------
    // [RULE12] modulo wrap
    assign ptr_inc = P_W'(ptr_i + 1'b1);
    assign ptr_dec = P_W'(ptr_i - 1'b1);
    assign ofs_ext = {{(P_W-O_W){offset_i[O_W-1]}}, offset_i};

    always_comb begin
        eff_addr_o = ptr_i;
        new_ptr_o = ptr_i;
        if (rel_i) begin
            // [RULE9] signed offset, pointer kept
            eff_addr_o = P_W'(ptr_i + ofs_ext);
        end else begin
            unique case (upd_i)
                // [RULE7] pre-modify forms
                UPD_PRE_INC: begin
                    eff_addr_o = ptr_inc;
                    new_ptr_o = ptr_inc;
                end
                UPD_PRE_DEC: begin
                    eff_addr_o = ptr_dec;
                    new_ptr_o = ptr_dec;
                end
                // [RULE8] post-modify forms
                UPD_POST_INC: begin
                    new_ptr_o = ptr_inc;
                end
                UPD_POST_DEC: begin
                    new_ptr_o = ptr_dec;
                end
            endcase
        end
    end

endmodule // smie_ptr_unit

// ==== smie_exec.sv ====
// execution block for right shift, file copy and indirect load
// assumes a synchronous data memory on the same clock: data one
// cycle after the read strobe; instruction ports from core logic
//
// Summary of operation
// [RULE1] Right shift clears result bit 7 and moves source bits 7:1 to 6:0.
// [RULE2] Right shift puts source bit 0 into the carry flag.
// [RULE3] Right shift writes W when d is 0 and the source file when d is 1.
// [RULE4] File copy loads W when d is 0 or rewrites the file when d is 1.
// [RULE5] File copy sets the zero flag from the moved value.
// [RULE6] Indirect load picks pointer 0 or 1 and loads W from its address.
// [RULE7] Code 00 pre-increments and code 01 pre-decrements the pointer.
// [RULE8] Code 10 post-increments and code 11 post-decrements the pointer.
// [RULE9] Relative form uses pointer plus signed offset, pointer unchanged.
// [RULE10] The alias addresses hold no storage of their own.
// [RULE11] Naming an alias address accesses the address in its pointer.
// [RULE12] Pointers are 16 bits wide and wrap silently at both ends.
// [RULE13] Zero flag follows the 8-bit result; pointer updates touch no flag.
`timescale 1ns/1ps

module smie_exec
    import smie_pkg::*;
#(
    parameter int A_W = PTR_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // instruction issue
    input wire logic issue_i,
    input wire smie_instr_t instr_i,
    input wire logic [BANK_W-1:0] bank_i,
    // pointer load from core
    input wire smie_ptr_load_t ptr_load_i,
    // data memory
    input wire logic [DATA_W-1:0] mem_rdata_i,
    output smie_mem_req_t mem_req_o,
    // architectural state
    output logic [DATA_W-1:0] w_o,
    output logic carry_o,
    output logic zero_o,
    output logic [A_W-1:0] ptr0_o,
    output logic [A_W-1:0] ptr1_o,
    // status
    output logic busy_o,
    output logic done_o
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (A_W != PTR_W) begin : g_bad
        $error("smie_exec: address width must equal pointer width");
    end
    // direct address must fit the pointer-wide memory address
    if (BANK_W + FADDR_W > A_W) begin : g_bad_bank
        $error("smie_exec: bank and file address wider than address");
    end
    // the offset is sign-extended, so it must be narrower
    if (OFS_W >= A_W) begin : g_bad_ofs
        $error("smie_exec: offset not narrower than pointer");
    end

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_EXEC = 3'h4
    } smie_state_t;

    typedef struct packed {
        smie_state_t state;
        smie_op_t op;
        logic dest;
        smie_mem_req_t mem;
        logic [DATA_W-1:0] w;
        logic carry;
        logic zero;
        logic [A_W-1:0] ptr0;
        logic [A_W-1:0] ptr1;
        logic busy;
        logic done;
    } smie_regs_t;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // [RULE13] zero test
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return (v == '0);
    endfunction

    function automatic logic is_alias(input logic [FADDR_W-1:0] f);
        return (f == ALIAS0_ADDR) || (f == ALIAS1_ADDR);
    endfunction

    // pointer selected by a one-bit index
    function automatic logic [A_W-1:0] pick_ptr(input logic sel,
        input logic [A_W-1:0] p0, input logic [A_W-1:0] p1);
        return sel ? p1 : p0;
    endfunction

    // pointer store into a copy of the state
    function automatic smie_regs_t put_ptr(input smie_regs_t s,
        input logic sel, input logic [A_W-1:0] v);
        smie_regs_t t;
        t = s;
        if (sel) begin
            t.ptr1 = v;
        end else begin
            t.ptr0 = v;
        end
        return t;
    endfunction

    // shift result below, outgoing bit 0 on top for the carry
    function automatic logic [DATA_W:0] lsr_byte(input logic [DATA_W-1:0] v);
        return {v[0], 1'b0, v[DATA_W-1:1]};
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_sync;

    // async assert, two-stage release keeps recovery clean
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // pointer arithmetic
    // ------------------------------------------------------------
    smie_regs_t r;
    smie_regs_t next_r;
    logic [A_W-1:0] sel_ptr;
    logic [A_W-1:0] ind_addr;
    logic [A_W-1:0] ind_new_ptr;

    // [RULE6] pointer chosen by select bit
    assign sel_ptr = pick_ptr(instr_i.ptr_sel, r.ptr0, r.ptr1);

    smie_ptr_unit #(
        .P_W(A_W),
        .O_W(OFS_W)
    ) u_ptr (
        .ptr_i(sel_ptr),
        .upd_i(instr_i.pointer_update_code),
        .rel_i(instr_i.rel),
        .offset_i(instr_i.offset),
        .eff_addr_o(ind_addr),
        .new_ptr_o(ind_new_ptr)
    );

    // ------------------------------------------------------------
    // issue decode
    // ------------------------------------------------------------
    logic take;

    // requests while busy or with no operation are dropped silently;
    // the core gets no refusal indication and must watch busy
    assign take = (r.state == ST_IDLE) && issue_i &&
        (instr_i.op != SMIE_OP_NONE);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [A_W-1:0] file_addr;
    logic [DATA_W-1:0] result;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.mem.rd_en = 1'b0;
        next_r.mem.wr_en = 1'b0;
        file_addr = A_W'({bank_i, instr_i.faddr});
        result = mem_rdata_i;

        // [RULE10] alias names map to pointers, no storage here
        // [RULE11] redirect through matching pointer
        if (is_alias(instr_i.faddr)) begin
            file_addr = pick_ptr(instr_i.faddr == ALIAS1_ADDR, r.ptr0, r.ptr1);
        end

        // core pointer loads; an instruction update of the
        // same pointer in the same cycle takes precedence
        if (ptr_load_i.wr) begin
            next_r = put_ptr(next_r, ptr_load_i.sel, ptr_load_i.data);
        end

        unique case (r.state)
            ST_IDLE: begin
                if (take) begin
                    next_r.state = ST_WAIT;
                    next_r.busy = 1'b1;
                    next_r.op = instr_i.op;
                    next_r.dest = instr_i.dest;
                    next_r.mem.rd_en = 1'b1;
                    next_r.mem.addr = file_addr;
                    if (instr_i.op == indirect_load_op) begin
                        // [RULE6] effective address from pointer
                        next_r.mem.addr = ind_addr;
                        // [RULE9] relative form stores nothing, so a
                        // core load of that pointer still lands
                        // [RULE12] wrapped pointer stored
                        if (!instr_i.rel) begin
                            next_r = put_ptr(next_r, instr_i.ptr_sel,
                                ind_new_ptr);
                        end
                    end
                end
            end
            ST_WAIT: begin
                // memory samples the address on this edge
                // and returns the byte before the following edge
                next_r.state = ST_EXEC;
            end
            ST_EXEC: begin
                next_r.state = ST_IDLE;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                unique case (r.op)
                    logical_right_shift_op: begin
                        // [RULE1] [RULE2] zero in, bit 0 to carry
                        {next_r.carry, result} = lsr_byte(mem_rdata_i);
                    end
                    file_copy_op: begin
                        // [RULE5] value unchanged, flag updated
                        result = mem_rdata_i;
                    end
                    default: begin
                        result = mem_rdata_i;
                    end
                endcase
                // [RULE13] zero flag from result
                next_r.zero = is_zero(result);
                if (r.op == indirect_load_op) begin
                    // indirect load ignores d and always targets W
                    // [RULE6] load W from target
                    next_r.w = result;
                end else if (r.dest == DEST_W) begin
                    // [RULE3] [RULE4] destination W
                    next_r.w = result;
                end else begin
                    // [RULE3] [RULE4] write back to file
                    next_r.mem.wr_en = 1'b1;
                    next_r.mem.wdata = result;
                end
            end
            default: begin
                next_r.state = ST_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            r.state <= ST_IDLE;
            r.op <= SMIE_OP_NONE;
            r.dest <= DEST_W;
            r.mem <= '0;
            r.w <= W_RST;
            r.carry <= CARRY_RST;
            r.zero <= ZERO_RST;
            r.ptr0 <= PTR_RST;
            r.ptr1 <= PTR_RST;
            r.busy <= 1'b0;
            r.done <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // write-back reuses the address of the read, which already
    // carries any alias redirection
    assign mem_req_o = r.mem;
    assign w_o = r.w;
    assign carry_o = r.carry;
    assign zero_o = r.zero;
    assign ptr0_o = r.ptr0;
    assign ptr1_o = r.ptr1;
    assign busy_o = r.busy;
    assign done_o = r.done;

endmodule // smie_exec

// ==== smie_exec_sva.sv ====
// assertions on the ports of the execution block
// assumes the bind below and idle issue only after reset release
`timescale 1ns/1ps
module smie_exec_sva
    import smie_pkg::*;
#(
    parameter int A_W = PTR_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic issue_i,
    input wire smie_instr_t instr_i,
    input wire smie_ptr_load_t ptr_load_i,
    input wire smie_mem_req_t mem_req_o,
    input wire logic [DATA_W-1:0] w_o,
    input wire logic carry_o,
    input wire logic zero_o,
    input wire logic [A_W-1:0] ptr0_o,
    input wire logic [A_W-1:0] ptr1_o,
    input wire logic busy_o,
    input wire logic done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // helpers: op of the instruction in flight
    // ----
    logic take;
    logic ind;
    logic [A_W-1:0] cur;
    logic [A_W-1:0] nxt;
    logic [A_W-1:0] rea;
    smie_op_t op_q;
    logic d_q;
    assign take = !busy_o && issue_i && instr_i.op != SMIE_OP_NONE;
    assign ind = take && instr_i.op == indirect_load_op && !ptr_load_i.wr;
    assign cur = instr_i.ptr_sel ? ptr1_o : ptr0_o;
    assign nxt = instr_i.pointer_update_code[0] ? cur - A_W'(1) :
        cur + A_W'(1);
    assign rea = cur + A_W'(signed'(instr_i.offset));
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_q <= SMIE_OP_NONE;
            d_q <= 1'b0;
        end else if (take) begin
            op_q <= instr_i.op;
            d_q <= instr_i.dest;
        end
    end
    sequence s_flight;
        busy_o && !done_o ##1 busy_o && !done_o;
    endsequence
    sequence s_commit;
        !busy_o && done_o;
    endsequence
    // ----
    // properties
    // ----
    issue_timing_a: assert property (
        take |=> s_flight ##1 s_commit)
        else $error("commit not two edges after take");
    idle_hold_a: assert property (!busy_o && !take |=> !busy_o && !done_o)
        else $error("activity without a take");
    read_start_a: assert property (
        take |=> mem_req_o.rd_en ##1 !mem_req_o.rd_en)
        else $error("read strobe not one cycle after take");
    pre_addr_a: assert property (ind && !instr_i.rel
        && !instr_i.pointer_update_code[1] |=> mem_req_o.addr == $past(nxt)
        && ($past(instr_i.ptr_sel) ? ptr1_o : ptr0_o) == $past(nxt))
        else $error("pre-modify address or pointer wrong");
    post_addr_a: assert property (ind && !instr_i.rel
        && instr_i.pointer_update_code[1] |=> mem_req_o.addr == $past(cur)
        && ($past(instr_i.ptr_sel) ? ptr1_o : ptr0_o) == $past(nxt))
        else $error("post-modify address or pointer wrong");
    rel_addr_a: assert property (ind && instr_i.rel
        |=> mem_req_o.addr == $past(rea)
        && ($past(instr_i.ptr_sel) ? ptr1_o : ptr0_o) == $past(cur))
        else $error("relative address or pointer wrong");
    write_commit_a: assert property (mem_req_o.wr_en |-> done_o)
        else $error("write outside commit");
    shift_msb_a: assert property (done_o
        && op_q == logical_right_shift_op
        && mem_req_o.wr_en |-> !mem_req_o.wdata[DATA_W-1])
        else $error("shift result msb set");
    zero_w_a: assert property (done_o
        && (op_q == indirect_load_op || !d_q)
        |-> zero_o == (w_o == '0))
        else $error("zero flag disagrees with w");
    zero_wr_a: assert property (done_o && mem_req_o.wr_en
        |-> zero_o == (mem_req_o.wdata == '0))
        else $error("zero flag disagrees with write data");
    carry_keep_a: assert property (done_o
        && op_q != logical_right_shift_op
        |-> $stable(carry_o))
        else $error("carry changed by non-shift");
endmodule // smie_exec_sva

bind smie_exec smie_exec_sva #(.A_W(A_W)) u_sva (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .issue_i(issue_i), .instr_i(instr_i),
    .ptr_load_i(ptr_load_i), .mem_req_o(mem_req_o), .w_o(w_o),
    .carry_o(carry_o), .zero_o(zero_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o),
    .busy_o(busy_o), .done_o(done_o));

// ==== tb.sv ====
// self-checking bench for the execution block
// assumes a behavioural byte memory answering while the read is pending
`timescale 1ns/1ps
module tb;
    import smie_pkg::*;
    typedef struct packed {
        logic [7:0] w;
        logic c;
        logic z;
        logic [15:0] p0;
        logic [15:0] p1;
        logic wr;
        logic [15:0] a;
        logic [7:0] d;
    } smie_exp_t;
    logic clk;
    logic rst_n = 1'b0;
    logic issue = 1'b0;
    smie_instr_t instr = '0;
    logic [4:0] bank = '0;
    smie_ptr_load_t pld = '0;
    logic [7:0] rdata;
    smie_mem_req_t mreq;
    logic [7:0] w;
    logic c, z, busy, done, rdv;
    logic [15:0] p0, p1;
    logic [7:0] mem [0:65535];
    logic [7:0] mw;
    logic mc, mz;
    logic [15:0] mp [2];
    smie_exp_t q [$];
    int n_fail = 0;
    int n_compared = 0;
    smie_exec u_dut (.clk_i(clk), .rst_n_i(rst_n), .issue_i(issue),
        .instr_i(instr), .bank_i(bank), .ptr_load_i(pld),
        .mem_rdata_i(rdata), .mem_req_o(mreq), .w_o(w), .carry_o(c),
        .zero_o(z), .ptr0_o(p0), .ptr1_o(p1), .busy_o(busy), .done_o(done));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----
    // memory: inverse data once the read is over, never a stale byte
    // ----
    always @(posedge clk) begin
        rdv <= mreq.rd_en;
        if (mreq.wr_en) mem[mreq.addr] <= mreq.wdata;
    end
    assign rdata = (mreq.rd_en || rdv) ? mem[mreq.addr] : ~mem[mreq.addr];
    task automatic chk(smie_exp_t g, smie_exp_t e);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %0t got %h exp %h", $time, g, e);
            n_fail++;
        end
    endtask
    task automatic mreset();
        mw = W_RST;
        mc = CARRY_RST;
        mz = ZERO_RST;
        mp[0] = PTR_RST;
        mp[1] = PTR_RST;
    endtask
    task automatic pload(logic s, logic [15:0] v);
        @(posedge clk);
        pld <= '{1'b1, s, v};
        mp[s] = v;
        @(posedge clk);
        pld.wr <= 1'b0;
    endtask
    task automatic exec(smie_op_t op, logic [6:0] f, logic d, logic s,
        logic [1:0] u, logic r, logic [5:0] o, logic hold);
        logic [15:0] a;
        logic [15:0] p;
        logic [7:0] v;
        logic [4:0] b;
        smie_exp_t e;
        b = 5'($urandom);
        p = mp[s];
        a = f == ALIAS0_ADDR ? mp[0] : f == ALIAS1_ADDR ? mp[1] : {4'h0, b, f};
        if (op == indirect_load_op) begin
            a = r ? p + 16'(signed'(o)) :
                u[1] ? p : u[0] ? p - 16'h1 : p + 16'h1;
            if (!r) mp[s] = u[0] ? p - 16'h1 : p + 16'h1;
        end
        v = mem[a];
        e = '0;
        if (op == logical_right_shift_op) begin
            mc = v[0];
            v = {1'b0, v[7:1]};
        end
        mz = v == 8'h00;
        if (op == indirect_load_op || !d) mw = v;
        else e = '{8'h00, 1'b0, 1'b0, 16'h0, 16'h0, 1'b1, a, v};
        e.w = mw;
        e.c = mc;
        e.z = mz;
        e.p0 = mp[0];
        e.p1 = mp[1];
        q.push_back(e);
        @(posedge clk);
        issue <= 1'b1;
        instr <= '{op, f, d, s, u, r, o};
        bank <= b;
        @(posedge clk);
        issue <= hold;
        repeat (2) @(posedge clk);
        issue <= 1'b0;
        // let a write-back land before the next expectation reads memory
        @(posedge clk);
        @(negedge clk);
    endtask
    // ----
    // monitor: each commit takes the oldest expectation
    // ----
    always @(posedge clk) begin
        smie_exp_t g;
        smie_exp_t e;
        if (done === 1'b1) begin
            g = '{w, c, z, p0, p1, mreq.wr_en, mreq.addr, mreq.wdata};
            e = q.size() ? q.pop_front() : '1;
            if (!e.wr) g.a = '0;
            if (!e.wr) g.d = '0;
            chk(g, e);
        end
    end
    task automatic conclude();
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        conclude();
    end
    initial begin
        logic [31:0] x;
        void'($urandom(78329));
        foreach (mem[i]) mem[i] = 8'($urandom);
        mem[16'h0123] = 8'h01;
        mem[16'h0200] = 8'h00;
        mreset();
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        pload(1'b0, 16'hFFFF);
        pload(1'b1, 16'h0000);
        for (int u = 0; u < 4; u++) begin
            exec(indirect_load_op, 7'h0, 1'b0, 1'b0, 2'(u), 1'b0, 6'h0,
                1'b0);
            exec(indirect_load_op, 7'h0, 1'b0, 1'b1, 2'(u), 1'b0, 6'h0,
                1'b0);
        end
        exec(indirect_load_op, 7'h0, 1'b0, 1'b0, 2'h0, 1'b1, 6'h20,
            1'b0);
        exec(indirect_load_op, 7'h0, 1'b0, 1'b0, 2'h3, 1'b1, 6'h1F,
            1'b0);
        pload(1'b0, 16'h0123);
        pload(1'b1, 16'h0200);
        exec(logical_right_shift_op, ALIAS0_ADDR, DEST_FILE, 1'b0, 2'h0,
            1'b0, 6'h0, 1'b0);
        exec(logical_right_shift_op, ALIAS1_ADDR, DEST_W, 1'b0, 2'h0,
            1'b0, 6'h0, 1'b0);
        exec(file_copy_op, ALIAS1_ADDR, DEST_FILE, 1'b0, 2'h0,
            1'b0, 6'h0, 1'b0);
        exec(file_copy_op, 7'h45, DEST_W, 1'b0, 2'h0,
            1'b0, 6'h0, 1'b1);
        // an issue with no operation must be dropped
        @(posedge clk);
        issue <= 1'b1;
        instr.op <= SMIE_OP_NONE;
        @(posedge clk);
        issue <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            x = $urandom;
            if (x[31]) pload(x[30], x[29:14]);
            exec(smie_op_t'($urandom_range(3, 1)), x[6:0], x[7], x[8],
                x[10:9], x[11], x[17:12], x[18]);
        end
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk('{w, c, z, p0, p1, mreq.wr_en, mreq.addr, mreq.wdata}, '0);
        mreset();
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        exec(indirect_load_op, 7'h0, 1'b0, 1'b1, 2'h1, 1'b0, 6'h0,
            1'b0);
        repeat (4) @(posedge clk);
        if (q.size() != 0) begin
            $display("[ERR] %0t left %h exp %h", $time, q.size(), 0);
            n_fail++;
        end
        conclude();
    end
endmodule // tb
